/* File: core/rtr_consts.svh */
// constants of the trigger readout reformatter: offsets, fields, resets, labels
// assumes inclusion from the package and from the reformatter module only
`ifndef RTR_CONSTS_SVH
`define RTR_CONSTS_SVH
// ==================================================================
// register byte offsets
`define RTR_ADDR_CTRL   8'h00
`define RTR_ADDR_SRCID  8'h04
`define RTR_ADDR_LIMIT  8'h08
`define RTR_ADDR_STAT   8'h0C
`define RTR_ADDR_WCNT   8'h10
// ==================================================================
// reset values
`define RTR_CTRL_RST    32'h0000_0000
`define RTR_SRCID_RST   8'h00
`define RTR_LIMIT_RST   16'hFFFF
// ==================================================================
// field positions
`define RTR_CTRL_MODE   2:0
`define RTR_CTRL_EN     3
`define RTR_CTRL_TENB   4
`define RTR_CTRL_JFWD   5
`define RTR_CTRL_FMSK   31:16
`define RTR_SRC_MOD     3:0
`define RTR_SRC_CRATE   7:4
`define RTR_STAT_LIM    0
`define RTR_STAT_FOVF   1
`define RTR_STAT_OVR    2
`define RTR_STAT_BUSY   3
`define RTR_STAT_PERR   4
// ==================================================================
// mode codes
`define RTR_MODE_CPM    3'h0
`define RTR_MODE_JEM    3'h1
`define RTR_MODE_MCP    3'h2
`define RTR_MODE_MJET   3'h3
`define RTR_MODE_MEN    3'h4
`define RTR_MODE_CROI   3'h5
`define RTR_MODE_JROI   3'h6
// ==================================================================
// frame lengths in link bits, per pin
`define RTR_LEN_CPM     7'h54
`define RTR_LEN_JEM     7'h44
`define RTR_LEN_CMM     7'h4C
`define RTR_LEN_CROI    7'h14
`define RTR_LEN_JROI    7'h42
// ==================================================================
// pins, slots and labels
`define RTR_PIN_LAST    5'h13
`define RTR_SLOT_LAST   3'h4
`define RTR_PIN_JLAST   5'h0E
`define RTR_PIN_JSUM    5'h0F
`define RTR_PIN_CPOVF   13
`define RTR_PIN_JOVF    15
`define RTR_PIN_MODS    5'h10
`define RTR_LBL_BASE    5'h14
`define RTR_LBL_JCNT3   5'h14
`define RTR_LBL_JCNT2   5'h15
`define RTR_LBL_JESUM   5'h16
`define RTR_LBL_LOC     5'h16
`define RTR_LBL_SUB2    5'h18
`define RTR_LBL_TOT     5'h1A
`endif

/* File: core/rtr_pkg.sv */
// types of the trigger readout reformatter
// assumes rtr_consts.svh sits beside it on the include path
package rtr_pkg;
`include "rtr_consts.svh"
    typedef enum logic [2:0] {
        RTR_CPM_DAQ  = `RTR_MODE_CPM,
        RTR_JEM_DAQ  = `RTR_MODE_JEM,
        RTR_MCP_DAQ  = `RTR_MODE_MCP,
        RTR_MJET_DAQ = `RTR_MODE_MJET,
        RTR_MEN_DAQ  = `RTR_MODE_MEN,
        RTR_CPM_ROI  = `RTR_MODE_CROI,
        RTR_JEM_ROI  = `RTR_MODE_JROI
    } rtr_mode_e;
    typedef enum logic [2:0] {
        RTR_IDLE  = 3'b001,
        RTR_SCAN  = 3'b010,
        RTR_CLOSE = 3'b100
    } rtr_state_e;
    typedef struct packed {
        logic        valid;
        logic        last;
        logic        limited;
        logic [31:0] word;
    } rtr_frag_s;
endpackage

/* File: core/rtr_reformatter.sv */
// trigger readout reformatter: 20 serial pins in, fragment payload words out
// assumes an APB master on core_clk and a link clock far slower than core_clk
`timescale 1ns/100ps
`include "rtr_consts.svh"
// Overview of operation
// - cluster DAQ pin frame: 84 bits, towers with parity and link-down, hits, crossing
// - one word per tower pair: link-down field, pair 0-3, pin number 0-19
// - drop a tower-pair word whose towers, parity and link-down bits are zero
// - hit bits form two words, pins 0-7 and 8-15, each dropped if zero
// - jet channel frame is 11 bits; in 10-bit mode the error bit is data
// - 44 element pairs: three on pins 0-13, two on pin 14
// - pin 15 carries jet counts, energy sums and crossing number
// - one word per element pair with errors, pair counter and pin 0-14
// - drop an element-pair word when both 11-bit fields are zero
// - counts and sums carry source labels, two count formats, dropped if low 24 zero
// - cluster merger: hits on 0-13, sums on 14-18, overflow on pin 13
// - cluster merger words labelled by pin, low 25 zero dropped, overflow to status
// - jet merger: hits on 0-15, forward format option, overflow on pin 15
// - jet merger: 3-bit counts labelled by pin, 2-bit from 20 upward
// - energy merger: energies on 0-15, sums on 16-19, overflow on pin 15
// - energy labels: pin, sub-sums 20-25, totals 26-27, scalar sum 28
// - drop an energy word whose bits beside id and label are zero
// - region words fully addressed, counted against limit, rest of event dropped
// - cluster regions: two pins per chip, eight chips on pins 0-15
// - cluster region word: maps, error, saturation, coordinate and chip from pin
// - jet regions: frames on pins 0,1 and 3,4; odd pin parity
// - jet region word: frame 0-7, parity error, source ids; dropped if low 13 and error zero
// - limited-set flag goes with the fragment status, only for region data
module rtr_reformatter
    import rtr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lnk_clk,
    input  wire logic        lnk_dav,
    input  wire logic [19:0] lnk_pin,
    output rtr_frag_s        frag,
    output logic      [7:0]  sub_block_status_word
);
    // ==================================================================
    // registers and state
    logic [31:0] ctrl;
    logic [7:0]  srcid;
    logic [15:0] region_payload_limit;
    logic        ovr;
    logic        last_lim;
    logic [15:0] last_wcnt;
    rtr_state_e  st;
    logic [4:0]  pin;
    logic [2:0]  slot;
    logic [15:0] wcnt;
    logic        limited_set_flag;
    rtr_mode_e   mode;
    logic        en;
    logic        roi;

    assign mode = rtr_mode_e'(ctrl[`RTR_CTRL_MODE]);
    assign en   = ctrl[`RTR_CTRL_EN];
    assign roi  = (mode == RTR_CPM_ROI) || (mode == RTR_JEM_ROI);

    // ==================================================================
    // APB slave: answer on the second access cycle
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd;

    assign acc = psel & penable & ~pready;
    assign wr  = psel & penable & pready & pwrite;

    always_comb begin
        hit = 1'b1;
        rd  = 32'h0000_0000;
        case (paddr)
            `RTR_ADDR_CTRL:  rd = ctrl;
            `RTR_ADDR_SRCID: rd = {24'h00_0000, srcid};
            `RTR_ADDR_LIMIT: rd = {16'h0000, region_payload_limit};
            `RTR_ADDR_STAT:  rd = {27'h000_0000, sub_block_status_word[1], st != RTR_IDLE,
                                   ovr, sub_block_status_word[0], last_lim};
            `RTR_ADDR_WCNT:  rd = {16'h0000, last_wcnt};
            default:         hit = 1'b0;
        endcase
    end

    // pready, data and error are all registered so every output leaves a flop
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~hit;
            prdata  <= (acc & ~pwrite) ? rd : 32'h0000_0000;
        end
    end

    // software registers take writes only at the completing edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl                 <= `RTR_CTRL_RST;
            srcid                <= `RTR_SRCID_RST;
            region_payload_limit <= `RTR_LIMIT_RST;
        end else if (wr) begin
            if (paddr == `RTR_ADDR_CTRL)
                ctrl <= pwdata;
            if (paddr == `RTR_ADDR_SRCID)
                srcid <= pwdata[7:0];
            if (paddr == `RTR_ADDR_LIMIT)
                region_payload_limit <= pwdata[15:0];
        end
    end

    // ==================================================================
    // link sampling: two flops on every pin, edge found on the synced clock
    logic        lck_s1;
    logic        lck_s2;
    logic        lck_s3;
    logic [20:0] din_s1;
    logic [20:0] din_s2;
    logic        rise;
    logic        dav;
    logic [6:0]  bcnt;
    logic [6:0]  flen;
    logic        done;
    logic        cap;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lck_s1 <= 1'b0;
            lck_s2 <= 1'b0;
            lck_s3 <= 1'b0;
            din_s1 <= 21'h00_0000;
            din_s2 <= 21'h00_0000;
        end else begin
            lck_s1 <= lnk_clk;
            lck_s2 <= lck_s1;
            lck_s3 <= lck_s2;
            din_s1 <= {lnk_dav, lnk_pin};
            din_s2 <= din_s1;
        end
    end

    assign rise = lck_s2 & ~lck_s3;
    assign dav  = din_s2[20];
    assign cap  = done & (st == RTR_IDLE);

    // frame length per source format
    always_comb begin
        unique case (mode)
            RTR_CPM_DAQ:  flen = `RTR_LEN_CPM;
            RTR_JEM_DAQ:  flen = `RTR_LEN_JEM;
            RTR_CPM_ROI:  flen = `RTR_LEN_CROI;
            RTR_JEM_ROI:  flen = `RTR_LEN_JROI;
            default:      flen = `RTR_LEN_CMM;
        endcase
    end

    // bit counter; data-valid low realigns, so a cut frame cannot skew the next one
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bcnt <= 7'h00;
            done <= 1'b0;
        end else begin
            done <= en & rise & dav & (bcnt == flen - 7'h01);
            if (!en || !dav)
                bcnt <= 7'h00;
            else if (rise)
                bcnt <= (bcnt == flen - 7'h01) ? 7'h00 : bcnt + 7'h01;
        end
    end

    // ==================================================================
    // per-pin shift and hold registers; hold is frozen while a scan runs
    logic [83:0] sh   [20];
    logic [83:0] hold [20];
    logic [19:0] perr;
    logic [19:0] sperr;
    logic [47:0] hits;

    genvar p;
    generate
        for (p = 0; p < 20; p++) begin : g_pin
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b)
                    sh[p] <= 84'h0;
                else if (en && rise && dav && bcnt == 7'h00)
                    sh[p] <= {83'h0, din_s2[p]};
                else if (en && rise && dav)
                    sh[p][bcnt] <= din_s2[p];
            end
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b)
                    hold[p] <= 84'h0;
                else if (cap)
                    hold[p] <= sh[p];
            end
            // good frames carry odd longitudinal parity
            assign perr[p] = ~^hold[p];
            assign sperr[p] = ~^sh[p];
            if (p < 16) begin : g_hit
                assign hits[3*p +: 3] = hold[p][2:0];
            end
        end
    endgenerate

    // ==================================================================
    // word builder for the current pin and slot
    logic [83:0] f;
    logic [19:0] seg20;
    logic [21:0] seg22;
    logic [24:0] seg25;
    logic [15:0] seg16;
    logic [31:0] cw;
    logic        ex;
    logic        sp;

    always_comb begin
        f     = hold[pin];
        seg20 = 20'(f >> (7'd3 + 7'd20 * slot));
        seg22 = 22'(f >> (7'd1 + 7'd22 * slot));
        seg25 = 25'(f >> (7'd1 + 7'd25 * slot));
        seg16 = 16'(f >> (7'd1 + {slot, 4'h0}));
        cw    = 32'h0000_0000;
        ex    = 1'b0;
        sp    = 1'b1;
        unique case (mode)
            RTR_CPM_DAQ: begin
                if (slot < `RTR_SLOT_LAST) begin
                    ex        = 1'b1;
                    cw[7:0]   = seg20[7:0];
                    cw[8]     = seg20[8];
                    cw[16:9]  = seg20[17:10];
                    cw[17]    = seg20[18];
                    cw[19:18] = {seg20[19], seg20[9]};
                    cw[21:20] = slot[1:0];
                    cw[26:22] = pin;
                    sp        = (seg20 == 20'h0_0000);
                end else if (pin < 5'h02) begin
                    ex        = 1'b1;
                    cw[23:0]  = pin[0] ? hits[47:24] : hits[23:0];
                    cw[28:24] = `RTR_LBL_BASE + pin;
                    sp        = (cw[23:0] == 24'h00_0000);
                end
            end
            RTR_JEM_DAQ: begin
                if ((pin < `RTR_PIN_JLAST && slot < 3'h3)
                    || (pin == `RTR_PIN_JLAST && slot < 3'h2)) begin
                    ex        = 1'b1;
                    cw[21:0]  = seg22;
                    cw[23:22] = slot[1:0];
                    cw[28:24] = pin;
                    cw[29]    = ctrl[`RTR_CTRL_TENB];
                    sp        = (seg22 == 22'h00_0000);
                end else if (pin == `RTR_PIN_JSUM && slot < 3'h2) begin
                    ex        = 1'b1;
                    cw[24:0]  = seg25;
                    if (slot != 3'h0)
                        cw[29:25] = `RTR_LBL_JESUM;
                    else if (ctrl[`RTR_CTRL_JFWD])
                        cw[29:25] = `RTR_LBL_JCNT2;
                    else
                        cw[29:25] = `RTR_LBL_JCNT3;
                    sp        = (seg25[23:0] == 24'h00_0000);
                end
            end
            RTR_MCP_DAQ: begin
                ex        = (pin < `RTR_PIN_LAST) && (slot == 3'h0);
                cw[24:0]  = seg25;
                cw[29:25] = pin;
                sp        = (seg25 == 25'h000_0000);
            end
            RTR_MJET_DAQ: begin
                ex        = (slot == 3'h0);
                cw[24:0]  = seg25;
                if (pin < `RTR_PIN_MODS && ctrl[16 + pin[3:0]])
                    cw[29:25] = `RTR_LBL_BASE + {3'h0, pin[3], pin[0]};
                else
                    cw[29:25] = pin;
                sp        = (seg25 == 25'h000_0000);
            end
            RTR_MEN_DAQ: begin
                sp = (seg25 == 25'h000_0000);
                cw[24:0] = seg25;
                if (pin < `RTR_PIN_MODS) begin
                    ex        = (slot == 3'h0);
                    cw[29:25] = pin;
                end else if (pin == `RTR_PIN_LAST - 5'h01) begin
                    ex        = (slot < 3'h3);
                    cw[29:25] = `RTR_LBL_TOT + {2'h0, slot};
                end else begin
                    ex = (slot < 3'h2);
                    unique case (pin[1:0])
                        2'h0:    cw[29:25] = `RTR_LBL_BASE + {2'h0, slot};
                        2'h1:    cw[29:25] = `RTR_LBL_LOC + {2'h0, slot};
                        default: cw[29:25] = `RTR_LBL_SUB2 + {2'h0, slot};
                    endcase
                end
            end
            RTR_CPM_ROI: begin
                ex        = (pin < `RTR_PIN_MODS) && (slot == 3'h0);
                cw[17:0]  = f[18:1];
                cw[18]    = pin[0];
                cw[21:19] = pin[3:1];
                cw[25:22] = srcid[`RTR_SRC_MOD];
                cw[29:26] = srcid[`RTR_SRC_CRATE];
                sp        = (f[18:1] == 18'h0_0000);
            end
            RTR_JEM_ROI: begin
                ex        = (pin < 5'h05) && (pin != 5'h02)
                            && (slot < `RTR_SLOT_LAST);
                cw[15:0]  = seg16;
                cw[16]    = perr[pin];
                cw[19:17] = {(pin == 5'h01) || (pin == 5'h04), slot[1:0]};
                cw[20]    = (pin > 5'h02);
                cw[24:21] = srcid[`RTR_SRC_MOD];
                cw[28:25] = srcid[`RTR_SRC_CRATE];
                sp        = ({seg16[12:0], perr[pin]} == 14'h0000);
            end
            default: begin
                ex = 1'b0;
            end
        endcase
    end

    // ==================================================================
    // scan sequencer: one pin/slot position per cycle, 100 positions
    logic emit;
    logic at_limit;

    assign emit     = (st == RTR_SCAN) & ex & ~sp;
    assign at_limit = roi & (wcnt + 16'h0001 == region_payload_limit);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st               <= RTR_IDLE;
            pin              <= 5'h00;
            slot             <= 3'h0;
            wcnt             <= 16'h0000;
            limited_set_flag <= 1'b0;
        end else begin
            unique case (st)
                RTR_IDLE: begin
                    pin  <= 5'h00;
                    slot <= 3'h0;
                    if (cap) begin
                        st               <= RTR_SCAN;
                        wcnt             <= 16'h0000;
                        limited_set_flag <= 1'b0;
                    end
                end
                RTR_SCAN: begin
                    if (emit)
                        wcnt <= wcnt + 16'h0001;
                    if (emit && at_limit) begin
                        // the rest of the event is discarded
                        limited_set_flag <= 1'b1;
                        st               <= RTR_CLOSE;
                    end else if (slot == `RTR_SLOT_LAST) begin
                        slot <= 3'h0;
                        pin  <= pin + 5'h01;
                        if (pin == `RTR_PIN_LAST)
                            st <= RTR_CLOSE;
                    end else begin
                        slot <= slot + 3'h1;
                    end
                end
                RTR_CLOSE: begin
                    st <= RTR_IDLE;
                end
            endcase
        end
    end

    // fragment output: words, then one closing pulse carrying the flag
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frag <= '0;
        end else begin
            frag.valid   <= emit;
            frag.word    <= emit ? cw : 32'h0000_0000;
            frag.last    <= (st == RTR_CLOSE);
            frag.limited <= (st == RTR_CLOSE) & limited_set_flag;
        end
    end

    // ==================================================================
    // status: per-frame flags, overrun sticky until written one
    logic        fovf;
    logic [19:0] pmask;

    // only pins that carry longitudinal parity in the current format are checked
    assign pmask = (mode == RTR_CPM_ROI) ? 20'h0_FFFF
                 : (mode == RTR_JEM_ROI) ? 20'h0_001F : 20'hF_FFFF;

    always_comb begin
        unique case (mode)
            RTR_MCP_DAQ:  fovf = sh[`RTR_PIN_CPOVF][0];
            RTR_MJET_DAQ: fovf = sh[`RTR_PIN_JOVF][0];
            RTR_MEN_DAQ:  fovf = sh[`RTR_PIN_JOVF][0];
            default:      fovf = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_block_status_word <= 8'h00;
            ovr                   <= 1'b0;
            last_lim              <= 1'b0;
            last_wcnt             <= 16'h0000;
        end else begin
            if (cap)
                sub_block_status_word <= {6'h00, |(sperr & pmask), fovf};
            // a frame ending mid-scan is lost; set wins over the clear
            if (done && st != RTR_IDLE)
                ovr <= 1'b1;
            else if (wr && paddr == `RTR_ADDR_STAT && pwdata[`RTR_STAT_OVR])
                ovr <= 1'b0;
            if (st == RTR_CLOSE) begin
                last_lim  <= limited_set_flag;
                last_wcnt <= wcnt;
            end
        end
    end

endmodule

/* File: verification/rtr_link_src.sv */
// link source model: shifts one frame out on the twenty serial pins
// assumes the reformatter samples the pins on the rising link clock
`timescale 1ns/100ps
module rtr_link_src (
    output logic        lnk_clk,
    output logic        lnk_dav,
    output logic [19:0] lnk_pin
);
    // ====
    // idle levels
    initial begin
        lnk_clk = 1'h0;
        lnk_dav = 1'h0;
        lnk_pin = 20'h0;
    end
    // clock stands still between frames; data moves only while it is low
    task automatic send(input logic [83:0] fr [20], input int len);
        logic [19:0] v;
        for (int k = 0; k < len; k++) begin
            for (int p = 0; p < 20; p++) v[p] = fr[p][k];
            lnk_dav <= 1'h1;
            lnk_pin <= v;
            #40 lnk_clk <= 1'h1;
            #40 lnk_clk <= 1'h0;
        end
        lnk_dav <= 1'h0;
        lnk_pin <= ~lnk_pin; // released pins must not look like stale data
    endtask
endmodule

/* File: verification/rtr_reformatter_assertions.sv */
// checker on the reformatter ports: bus answer, payload words, closing
// assumes one clock domain and binding into every rtr_reformatter
`timescale 1ns/100ps
module rtr_reformatter_assertions
    import rtr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire rtr_frag_s   frag,
    input wire logic [7:0]  sub_block_status_word
);
    // ====
    // properties on the core clock
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    apb_answer_a: assert property (psel && $rose(penable) |=> pready)
        else $error("pready not at second access edge");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    last_alone_a: assert property (frag.last |-> !frag.valid ##1 !frag.last)
        else $error("bad close pulse");
    limit_with_last_a: assert property (frag.limited |-> frag.last)
        else $error("limited without last");
    kept_nonzero_a: assert property (frag.valid |-> frag.word != 32'h0)
        else $error("zero word emitted");
    status_pad_a: assert property (sub_block_status_word[7:2] == 6'h0)
        else $error("status pad bits set");
    word_then_last_a: assert property (frag.valid |-> ##[1:120] frag.last)
        else $error("fragment not closed");
    // main scenarios
    kept_c: cover property (frag.valid);
    limited_c: cover property (frag.last && frag.limited);
    unmapped_c: cover property (pslverr);
endmodule
bind rtr_reformatter rtr_reformatter_assertions u_rtr_reformatter_assertions (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frag(frag),
    .sub_block_status_word(sub_block_status_word)
);

/* File: verification/testbench.sv */
// self-checking bench of the trigger readout reformatter
// assumes the link source model and the checker are compiled first
`timescale 1ns/100ps
module testbench
    import rtr_pkg::*;
;
    typedef struct packed {
        logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
    } rtr_row_s;
    // register rows: write flag, address, data, expected read, expected error
    localparam rtr_row_s ROWS [8] = '{
        '{1'h0, 8'h00, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h0, 1'h0},
        '{1'h0, 8'h08, 32'h0, 32'hFFFF, 1'h0}, '{1'h1, 8'h04, 32'h35, 32'h0, 1'h0},
        '{1'h0, 8'h04, 32'h0, 32'h35, 1'h0}, '{1'h1, 8'h10, 32'h7, 32'h0, 1'h0},
        '{1'h0, 8'h10, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h14, 32'h0, 32'h0, 1'h1}};
    logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic        lnk_clk, lnk_dav, got_last, got_lim, er;
    logic [7:0]  paddr, sub_block_status_word;
    logic [31:0] pwdata, prdata, rd;
    logic [19:0] lnk_pin;
    logic [31:0] q [$];
    logic [83:0] fr [20];
    rtr_frag_s   frag;
    int          errors, n_tests;
    rtr_reformatter u_rtr_reformatter (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk_clk(lnk_clk),
        .lnk_dav(lnk_dav), .lnk_pin(lnk_pin), .frag(frag),
        .sub_block_status_word(sub_block_status_word));
    rtr_link_src u_rtr_link_src (.lnk_clk(lnk_clk), .lnk_dav(lnk_dav), .lnk_pin(lnk_pin));
    // ====
    // clock and payload monitor
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (frag.valid === 1'h1) q.push_back(frag.word);
        if (frag.last === 1'h1) begin
            got_last = 1'h1;
            got_lim = frag.limited;
        end
    end
    // ====
    // tasks
    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        if (i >= 20) begin
            errors++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // one frame out, then a bounded wait for the fragment close
    task automatic run(input int len);
        int i;
        q = {};
        got_last = 1'h0;
        got_lim = 1'h0;
        u_rtr_link_src.send(fr, len);
        for (i = 0; i < 1500 && got_last !== 1'h1; i++) @(posedge core_clk);
        if (got_last !== 1'h1) begin
            errors++;
            conclude();
        end
        repeat (2) @(posedge core_clk);
    endtask
    // ====
    // main sequence
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {errors, n_tests, got_last, got_lim} = '0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        foreach (ROWS[i]) begin
            apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].wr) chk(rd, ROWS[i].x);
            chk({31'h0, er}, {31'h0, ROWS[i].e});
        end
        $display("done: registers");
        // cluster regions: two kept words among sixteen pins, odd parity
        apb(1'h1, 8'h00, 32'hD);
        foreach (fr[p]) fr[p] = 84'h0;
        fr[2][18:1] = 18'h2A5A3;
        fr[7][18:1] = 18'h00001;
        for (int p = 0; p < 16; p++) fr[p][19] = ~^fr[p][18:0];
        run(20);
        chk(q.size(), 2);
        chk(q[0], {2'h0, 4'h3, 4'h5, 3'h1, 1'h0, 18'h2A5A3});
        chk(q[1], {2'h0, 4'h3, 4'h5, 3'h3, 1'h1, 18'h00001});
        chk({24'h0, sub_block_status_word}, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h2);
        $display("done: region words");
        // limit of one word truncates the fragment
        apb(1'h1, 8'h08, 32'h1);
        run(20);
        chk(q.size(), 1);
        chk({31'h0, got_lim}, 32'h1);
        apb(1'h0, 8'h0C, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        $display("done: region limit");
        // broken parity on pin 0
        apb(1'h1, 8'h08, 32'hFFFF);
        fr[0][19] = ~fr[0][19];
        run(20);
        chk({31'h0, sub_block_status_word[1]}, 32'h1);
        chk({31'h0, got_lim}, 32'h0);
        $display("done: parity");
        // cluster merger: one word from pin 5, overflow on pin 13
        apb(1'h1, 8'h00, 32'hA);
        foreach (fr[p]) fr[p] = 84'h0;
        fr[5][25:1] = 25'h1ABCDEF;
        fr[13][0] = 1'h1;
        run(76);
        chk(q.size(), 1);
        chk(q[0], {2'h0, 5'h05, 25'h1ABCDEF});
        chk({31'h0, sub_block_status_word[0]}, 32'h1);
        chk({31'h0, got_lim}, 32'h0);
        $display("done: merger");
        // jet regions: one kept frame on pin 1 slot 2, odd parity on pins 0-4
        apb(1'h1, 8'h00, 32'hE);
        foreach (fr[p]) fr[p] = 84'h0;
        fr[1][48:33] = 16'h0ABC;
        for (int p = 0; p < 5; p++) fr[p][65] = ~^fr[p][64:0];
        run(66);
        chk(q.size(), 1);
        chk(q[0], {3'h0, 4'h3, 4'h5, 1'h0, 3'h6, 1'h0, 16'h0ABC});
        chk({24'h0, sub_block_status_word}, 32'h0);
        $display("done: jet regions");
        conclude();
    end
endmodule
